// *** urs_uart_rx_regs.svh ***
// Constants of the receive status and interrupt block of the serial port.
//
// Function
// - Level select 10 holds receive flag while buffer is three quarters full.
// - Level select 01 holds receive flag while buffer is half full.
// - Level select 00 holds receive flag while buffer holds a character.
// - Address detect treats a character with ninth bit one as address.
// - Address detect has no effect outside 9-bit character mode.
// - Idle bit reads one while no character is arriving.
// - Parity error bit shows the parity result of the current character.
// - Framing error bit shows the stop bit result of the current character.
// - Overrun sets on buffer overflow and clears only by a written zero.
// - Clearing a set overrun empties buffer and receive shift register.
// - Data available bit reads one while the buffer holds a character.
`ifndef URS_UART_RX_REGS_SVH
`define URS_UART_RX_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define URS_ADDR_W         12
`define URS_OFS_STATUS     12'h000
`define URS_OFS_CONFIG     12'h004
`define URS_OFS_RXDATA     12'h008
`define URS_OFS_IRQ_STAT   12'h00C
`define URS_OFS_IRQ_MASK   12'h010

// ****************************************************************
// Field positions
// ****************************************************************
`define URS_ST_LVL_HI      7
`define URS_ST_LVL_LO      6
`define URS_ST_ADDR_CHAR_DETECT_ENABLE       5
`define URS_ST_IDLE        4
`define URS_ST_PARITY_ERROR_FLAG        3
`define URS_ST_FRAMING_ERROR_FLAG        2
`define URS_ST_OVR         1
`define URS_ST_AVAIL       0
`define URS_CF_NINE        0
`define URS_CF_PAR_HI      2
`define URS_CF_PAR_LO      1
`define URS_CF_DIV_HI      31
`define URS_CF_DIV_LO      16
`define URS_IRQ_W          4
`define URS_IRQ_RXLVL      0
`define URS_IRQ_OVR        1
`define URS_IRQ_FRAMING_ERROR_FLAG       2
`define URS_IRQ_PARITY_ERROR_FLAG       3

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define URS_RST_LVL        2'h0
`define URS_RST_MASK       4'h0
`define URS_CLK_HZ         20000000
`define URS_BAUD_HZ        115200
`define URS_OVS            16
`define URS_RST_DIV        16'((`URS_CLK_HZ) / (`URS_OVS * `URS_BAUD_HZ))
`define URS_OVS_LAST       4'hF
`define URS_OVS_MID        4'h7
`define URS_DEPTH          8
`define URS_PTR_W          3
`define URS_CNT_W          4
`define URS_LVL_3Q         4'h6
`define URS_LVL_HALF       4'h4
`define URS_LVL_ONE        4'h1

`endif

// *** urs_pkg.sv ***
// Types shared by the receive status and interrupt block.
package urs_pkg;

  typedef enum logic [2:0] {
    URS_IDLE   = 3'b000,
    URS_START  = 3'b001,
    URS_DATA   = 3'b010,
    URS_PARITY = 3'b011,
    URS_STOP   = 3'b100
  } urs_state_t;

  typedef struct packed {
    logic       framing_error_flag;
    logic       parity_error_flag;
    logic [8:0] data;
  } urs_entry_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } urs_apb_req_t;

  typedef enum logic [2:0] {
    URS_SEL_STATUS = 3'b000,
    URS_SEL_CONFIG = 3'b001,
    URS_SEL_RXDATA = 3'b010,
    URS_SEL_ISTAT  = 3'b011,
    URS_SEL_IMASK  = 3'b100,
    URS_SEL_NONE   = 3'b111
  } urs_sel_t;

endpackage : urs_pkg

// *** urs_uart_rx.sv ***
// Receive path, status register and interrupt logic of the serial port.
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "urs_uart_rx_regs.svh"

module urs_uart_rx (
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  input  wire urs_pkg::urs_apb_req_t APB_REQ,
  output var  logic [31:0]           PRDATA,
  output var  logic                  PREADY,
  output var  logic                  PSLVERR,
  input  wire logic                  RX,
  output var  logic                  RX_IRQ_FLAG,
  output var  logic                  IRQ
);
  import urs_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic urs_sel_t reg_sel(input logic [11:0] addr);
    unique case (addr)
      `URS_OFS_STATUS:   reg_sel = URS_SEL_STATUS;
      `URS_OFS_CONFIG:   reg_sel = URS_SEL_CONFIG;
      `URS_OFS_RXDATA:   reg_sel = URS_SEL_RXDATA;
      `URS_OFS_IRQ_STAT: reg_sel = URS_SEL_ISTAT;
      `URS_OFS_IRQ_MASK: reg_sel = URS_SEL_IMASK;
      default:           reg_sel = URS_SEL_NONE;
    endcase
  endfunction : reg_sel

  // ****************************************************************
  // State declarations
  // ****************************************************************
  logic [2:0]          rx_sync_r;
  logic                rx_lvl_r, rx_lvl_nxt;
  logic [15:0]         div_cnt_r, div_cnt_nxt;
  logic                tick_r, tick_nxt;
  urs_state_t          state_r, state_nxt;
  logic [3:0]          os_cnt_r, os_cnt_nxt;
  logic [3:0]          bit_cnt_r, bit_cnt_nxt;
  logic [8:0]          shift_r, shift_nxt;
  logic                par_r, par_nxt;
  logic                done_r, done_nxt;
  logic                framing_error_flag_r, framing_error_flag_nxt;
  urs_entry_t          mem_r [`URS_DEPTH];
  urs_entry_t          mem_nxt [`URS_DEPTH];
  logic [2:0]          wr_ptr_r, wr_ptr_nxt;
  logic [2:0]          rd_ptr_r, rd_ptr_nxt;
  logic [3:0]          count_r, count_nxt;
  logic                ovr_r, ovr_nxt;
  logic [1:0]          lvl_r, lvl_nxt;
  logic                addr_char_detect_enable_r, addr_char_detect_enable_nxt;
  logic                nine_r, nine_nxt;
  logic [1:0]          par_mode_r, par_mode_nxt;
  logic [15:0]         div_r, div_nxt;
  logic [3:0]          istat_r, istat_nxt;
  logic [3:0]          imask_r, imask_nxt;
  logic                flag_r, flag_nxt;
  logic                irq_r, irq_nxt;
  logic                pready_r, pready_nxt;
  logic                pslverr_r, pslverr_nxt;
  logic [31:0]         prdata_r, prdata_nxt;

  logic                take;
  logic                wr_take;
  logic                pop;
  logic                ovr_clear;
  logic                accept;
  logic                push;
  logic                ovr_event;
  logic                parity_error_flag_new;
  logic [8:0]          char_data;
  urs_entry_t          head;
  urs_sel_t            sel;
  logic [31:0]         status_word;

  // ****************************************************************
  // Bus access qualifiers
  // ****************************************************************
  always_comb begin
    sel     = reg_sel(APB_REQ.paddr);
    take    = APB_REQ.psel & APB_REQ.penable & pready_r;
    wr_take = take & APB_REQ.pwrite;
    pop     = take & ~APB_REQ.pwrite & (sel == URS_SEL_RXDATA) &
              (count_r != 4'h0);
    ovr_clear = wr_take & (sel == URS_SEL_STATUS) & ovr_r &
                ~APB_REQ.pwdata[`URS_ST_OVR];
    head    = mem_r[rd_ptr_r];
  end

  // ****************************************************************
  // Pin synchroniser and oversampling divider
  // ****************************************************************
  always_comb begin
    rx_lvl_nxt = rx_lvl_r;
    if (rx_sync_r[1] == rx_sync_r[2]) begin
      rx_lvl_nxt = rx_sync_r[2];
    end
    tick_nxt    = (div_cnt_r == 16'h0000);
    div_cnt_nxt = div_cnt_r - 16'h0001;
    if (div_cnt_r == 16'h0000) begin
      div_cnt_nxt = (div_r == 16'h0000) ? 16'h0000 : div_r - 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rx_sync_r <= 3'h7;
      rx_lvl_r  <= 1'b1;
      div_cnt_r <= 16'h0000;
      tick_r    <= 1'b0;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], RX};
      rx_lvl_r  <= rx_lvl_nxt;
      div_cnt_r <= div_cnt_nxt;
      tick_r    <= tick_nxt;
    end
  end

  // ****************************************************************
  // Character receiver
  // ****************************************************************
  always_comb begin
    state_nxt   = state_r;
    os_cnt_nxt  = os_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    par_nxt     = par_r;
    framing_error_flag_nxt    = framing_error_flag_r;
    done_nxt    = 1'b0;
    if (tick_r) begin
      os_cnt_nxt = os_cnt_r + 4'h1;
      unique case (state_r)
        URS_IDLE: begin
          os_cnt_nxt = 4'h0;
          if (!rx_lvl_r) begin
            state_nxt = URS_START;
          end
        end
        URS_START: begin
          if (os_cnt_r == `URS_OVS_MID) begin
            os_cnt_nxt  = 4'h0;
            bit_cnt_nxt = 4'h0;
            shift_nxt   = 9'h000;
            state_nxt   = rx_lvl_r ? URS_IDLE : URS_DATA;
          end
        end
        URS_DATA: begin
          if (os_cnt_r == `URS_OVS_LAST) begin
            shift_nxt[bit_cnt_r] = rx_lvl_r;
            bit_cnt_nxt = bit_cnt_r + 4'h1;
            if (bit_cnt_r == (nine_r ? 4'h8 : 4'h7)) begin
              state_nxt = (!nine_r && par_mode_r != 2'h0) ?
                          URS_PARITY : URS_STOP;
            end
          end
        end
        URS_PARITY: begin
          if (os_cnt_r == `URS_OVS_LAST) begin
            par_nxt   = rx_lvl_r;
            state_nxt = URS_STOP;
          end
        end
        URS_STOP: begin
          if (os_cnt_r == `URS_OVS_LAST) begin
            framing_error_flag_nxt  = ~rx_lvl_r;
            done_nxt  = 1'b1;
            state_nxt = URS_IDLE;
          end
        end
        default: begin
          state_nxt = URS_IDLE;
        end
      endcase
    end
    if (ovr_clear) begin
      state_nxt = URS_IDLE;
      shift_nxt = 9'h000;
      done_nxt  = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      state_r   <= URS_IDLE;
      os_cnt_r  <= 4'h0;
      bit_cnt_r <= 4'h0;
      shift_r   <= 9'h000;
      par_r     <= 1'b0;
      framing_error_flag_r    <= 1'b0;
      done_r    <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      os_cnt_r  <= os_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      par_r     <= par_nxt;
      framing_error_flag_r    <= framing_error_flag_nxt;
      done_r    <= done_nxt;
    end
  end

  // ****************************************************************
  // Receive buffer and overrun
  // ****************************************************************
  always_comb begin
    char_data = nine_r ? shift_r : {1'b0, shift_r[7:0]};
    parity_error_flag_new  = 1'b0;
    if (!nine_r && par_mode_r == 2'h1) begin
      parity_error_flag_new = (^shift_r[7:0]) ^ par_r;
    end else if (!nine_r && par_mode_r == 2'h2) begin
      parity_error_flag_new = ~((^shift_r[7:0]) ^ par_r);
    end
    accept    = done_r & ~(nine_r & addr_char_detect_enable_r & ~shift_r[8]);
    ovr_event = accept & (count_r == 4'(`URS_DEPTH)) & ~ovr_r;
    push      = accept & ~ovr_r & (count_r != 4'(`URS_DEPTH));
    mem_nxt   = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = '{framing_error_flag: framing_error_flag_r, parity_error_flag: parity_error_flag_new, data: char_data};
      wr_ptr_nxt = wr_ptr_r + 3'h1;
    end
    if (pop) begin
      rd_ptr_nxt = rd_ptr_r + 3'h1;
    end
    count_nxt = count_r + {3'h0, push} - {3'h0, pop};
    ovr_nxt   = ovr_r;
    if (ovr_clear) begin
      ovr_nxt    = 1'b0;
      wr_ptr_nxt = 3'h0;
      rd_ptr_nxt = 3'h0;
      count_nxt  = 4'h0;
    end
    if (ovr_event) begin
      ovr_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    mem_r <= mem_nxt;
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      count_r  <= 4'h0;
      ovr_r    <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
      ovr_r    <= ovr_nxt;
    end
  end

  // ****************************************************************
  // Control registers, interrupt flag and interrupt status
  // ****************************************************************
  always_comb begin
    lvl_nxt      = lvl_r;
    addr_char_detect_enable_nxt    = addr_char_detect_enable_r;
    nine_nxt     = nine_r;
    par_mode_nxt = par_mode_r;
    div_nxt      = div_r;
    imask_nxt    = imask_r;
    if (wr_take && sel == URS_SEL_STATUS) begin
      lvl_nxt   = APB_REQ.pwdata[`URS_ST_LVL_HI:`URS_ST_LVL_LO];
      addr_char_detect_enable_nxt = APB_REQ.pwdata[`URS_ST_ADDR_CHAR_DETECT_ENABLE];
    end
    if (wr_take && sel == URS_SEL_CONFIG) begin
      nine_nxt     = APB_REQ.pwdata[`URS_CF_NINE];
      par_mode_nxt = APB_REQ.pwdata[`URS_CF_PAR_HI:`URS_CF_PAR_LO];
      div_nxt      = APB_REQ.pwdata[`URS_CF_DIV_HI:`URS_CF_DIV_LO];
    end
    if (wr_take && sel == URS_SEL_IMASK) begin
      imask_nxt = APB_REQ.pwdata[`URS_IRQ_W-1:0];
    end
    unique case (lvl_r)
      2'b10:   flag_nxt = (count_r >= `URS_LVL_3Q);
      2'b01:   flag_nxt = (count_r >= `URS_LVL_HALF);
      2'b00:   flag_nxt = (count_r >= `URS_LVL_ONE);
      2'b11:   flag_nxt = 1'b0;
    endcase
    istat_nxt = istat_r;
    if (wr_take && sel == URS_SEL_ISTAT) begin
      istat_nxt = istat_r & ~APB_REQ.pwdata[`URS_IRQ_W-1:0];
    end
    istat_nxt[`URS_IRQ_RXLVL] = istat_nxt[`URS_IRQ_RXLVL] | flag_r;
    istat_nxt[`URS_IRQ_OVR]   = istat_nxt[`URS_IRQ_OVR] | ovr_event;
    istat_nxt[`URS_IRQ_FRAMING_ERROR_FLAG]  = istat_nxt[`URS_IRQ_FRAMING_ERROR_FLAG] |
                                (push & framing_error_flag_r);
    istat_nxt[`URS_IRQ_PARITY_ERROR_FLAG]  = istat_nxt[`URS_IRQ_PARITY_ERROR_FLAG] |
                                (push & parity_error_flag_new);
    irq_nxt = |(istat_r & imask_r);
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      lvl_r      <= `URS_RST_LVL;
      addr_char_detect_enable_r    <= 1'b0;
      nine_r     <= 1'b0;
      par_mode_r <= 2'h0;
      div_r      <= `URS_RST_DIV;
      imask_r    <= `URS_RST_MASK;
      istat_r    <= 4'h0;
      flag_r     <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      lvl_r      <= lvl_nxt;
      addr_char_detect_enable_r    <= addr_char_detect_enable_nxt;
      nine_r     <= nine_nxt;
      par_mode_r <= par_mode_nxt;
      div_r      <= div_nxt;
      imask_r    <= imask_nxt;
      istat_r    <= istat_nxt;
      flag_r     <= flag_nxt;
      irq_r      <= irq_nxt;
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`URS_ST_LVL_HI:`URS_ST_LVL_LO] = lvl_r;
    status_word[`URS_ST_ADDR_CHAR_DETECT_ENABLE] = addr_char_detect_enable_r;
    status_word[`URS_ST_IDLE]  = (state_r == URS_IDLE);
    status_word[`URS_ST_PARITY_ERROR_FLAG]  = (count_r != 4'h0) & head.parity_error_flag;
    status_word[`URS_ST_FRAMING_ERROR_FLAG]  = (count_r != 4'h0) & head.framing_error_flag;
    status_word[`URS_ST_OVR]   = ovr_r;
    status_word[`URS_ST_AVAIL] = (count_r != 4'h0);
    pready_nxt  = APB_REQ.psel & APB_REQ.penable & ~pready_r;
    pslverr_nxt = pready_nxt & (sel == URS_SEL_NONE);
    prdata_nxt  = prdata_r;
    if (pready_nxt && !APB_REQ.pwrite) begin
      unique case (sel)
        URS_SEL_STATUS: prdata_nxt = status_word;
        URS_SEL_CONFIG: prdata_nxt = {div_r, 13'h0000, par_mode_r, nine_r};
        URS_SEL_RXDATA: prdata_nxt = (count_r == 4'h0) ? 32'h0000_0000 :
                                     {21'h000000, head};
        URS_SEL_ISTAT:  prdata_nxt = {28'h0000000, istat_r};
        URS_SEL_IMASK:  prdata_nxt = {28'h0000000, imask_r};
        URS_SEL_NONE:   prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  assign PREADY      = pready_r;
  assign PSLVERR     = pslverr_r;
  assign PRDATA      = prdata_r;
  assign RX_IRQ_FLAG = flag_r;
  assign IRQ         = irq_r;

endmodule : urs_uart_rx
`default_nettype wire

// *** urs_rx_sva.sv ***
// Checker that watches the port behaviour of the receive status block.
`timescale 1ns/10ps
`default_nettype none
`include "urs_uart_rx_regs.svh"

module urs_rx_sva (
  input wire logic                  CLK,
  input wire logic                  RST_B,
  input wire urs_pkg::urs_apb_req_t APB_REQ,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire logic                  RX,
  input wire logic                  RX_IRQ_FLAG,
  input wire logic                  IRQ
);
  import urs_pkg::*;
  logic       hs, wr_st, rd_st, rd_is, mapped;
  logic [3:0] mask_r, mask_nxt;
  logic       ovr_r, ovr_nxt;
  logic [7:0] hi_r, hi_nxt;

  // ****************************************************************
  // Shadow state
  // ****************************************************************
  always_comb begin
    hs       = APB_REQ.psel && APB_REQ.penable && PREADY;
    wr_st    = hs && APB_REQ.pwrite && APB_REQ.paddr == `URS_OFS_STATUS;
    rd_st    = hs && !APB_REQ.pwrite && APB_REQ.paddr == `URS_OFS_STATUS;
    rd_is    = hs && !APB_REQ.pwrite && APB_REQ.paddr == `URS_OFS_IRQ_STAT;
    mapped   = APB_REQ.paddr inside {`URS_OFS_STATUS, `URS_OFS_CONFIG,
               `URS_OFS_RXDATA, `URS_OFS_IRQ_STAT, `URS_OFS_IRQ_MASK};
    mask_nxt = mask_r;
    if (hs && APB_REQ.pwrite && APB_REQ.paddr == `URS_OFS_IRQ_MASK) begin
      mask_nxt = APB_REQ.pwdata[3:0];
    end
    ovr_nxt  = (ovr_r || (rd_st && PRDATA[1]))
               && !(wr_st && !APB_REQ.pwdata[1]);
    hi_nxt   = !RX ? 8'h00 : hi_r + 8'(hi_r != 8'hFF);
  end

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      mask_r <= 4'h0;
      ovr_r  <= 1'b0;
      hi_r   <= 8'h00;
    end else begin
      mask_r <= mask_nxt;
      ovr_r  <= ovr_nxt;
      hi_r   <= hi_nxt;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  sequence s_setup;
    APB_REQ.psel && !APB_REQ.penable;
  endsequence
  sequence s_access;
    APB_REQ.psel && APB_REQ.penable;
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence

  a_ready_wait: assert property (s_setup ##1 s_access |-> s_answer)
    else $error("answer not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_err_map: assert property (hs |-> PSLVERR == !mapped)
    else $error("error response does not match address");
  a_err_zero: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response without zero data");
  a_empty_clean: assert property (
    rd_st && !PRDATA[0] |-> PRDATA[3:2] == 2'h0 && PRDATA[31:8] == 24'h0)
    else $error("status of empty buffer not clean");
  a_flag_any: assert property (
    rd_st && PRDATA[7:6] == 2'h0 && PRDATA[0] |-> ##[0:1] RX_IRQ_FLAG)
    else $error("receive flag low with data present");
  a_flag_empty: assert property (
    rd_st && !PRDATA[0] |-> ##[0:1] !RX_IRQ_FLAG)
    else $error("receive flag high with empty buffer");
  a_mask_off: assert property (mask_r == 4'h0 && $past(mask_r) == 4'h0
    |-> !IRQ)
    else $error("interrupt high while fully masked");
  a_irq_pend: assert property (
    rd_is && (PRDATA[3:0] & mask_r) != 4'h0 |-> ##[0:1] IRQ)
    else $error("interrupt low with unmasked event");
  a_ovr_sticky: assert property (rd_st && ovr_r |-> PRDATA[1])
    else $error("overrun cleared without software");
  a_idle_quiet: assert property (
    rd_st && hi_r == 8'hFF |-> PRDATA[4])
    else $error("idle bit low on a quiet line");
endmodule : urs_rx_sva
`default_nettype wire

// *** urs_tx_model.sv ***
// Model of the remote serial transmitter that drives the receive line.
`timescale 1ns/10ps
`default_nettype none

module urs_tx_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  output var  logic rx
);
  initial rx = 1'b1;

  task automatic bit_out(input logic b);
    rx <= b;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : bit_out

  // Sends start, data LSB first, optional parity and stop.
  task automatic send(input logic [8:0] d, input logic nine,
                      input logic [1:0] par, input logic bad_par,
                      input logic bad_stop);
    logic p;
    p = (par == 2'b10) ^ (^d[7:0]) ^ bad_par;
    @(posedge clk);
    bit_out(1'b0);
    for (int i = 0; i < 8 + int'(nine); i++) begin
      bit_out(d[i]);
    end
    if (!nine && par != 2'b00) begin
      bit_out(p);
    end
    bit_out(!bad_stop);
    rx <= 1'b1;
  endtask : send
endmodule : urs_tx_model
`default_nettype wire

// *** test_uart_receive_status_irq.sv ***
// Self-checking testbench of the receive status and interrupt block.
`timescale 1ns/10ps
`default_nettype none
`include "urs_uart_rx_regs.svh"

module test_uart_receive_status_irq;
  import urs_pkg::*;
  logic         clk, rst_b, pready, pslverr, rx, rx_flag, irq, err;
  urs_apb_req_t req;
  logic [31:0]  prdata, rd;
  int           fail_count, checks;

  urs_uart_rx i_dut (
    .CLK         (clk),
    .RST_B       (rst_b),
    .APB_REQ     (req),
    .PRDATA      (prdata),
    .PREADY      (pready),
    .PSLVERR     (pslverr),
    .RX          (rx),
    .RX_IRQ_FLAG (rx_flag),
    .IRQ         (irq)
  );
  urs_tx_model i_tx (
    .clk (clk),
    .rx  (rx)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    req <= '0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string name, input logic [11:0] a,
                       input logic [31:0] m, exp);
    apb(1'b0, a, 32'h0);
    check(name, rd & m, exp);
  endtask : rdchk

  task automatic tx(input logic [8:0] d, input logic nine,
                    input logic [1:0] par, input logic bp, bs);
    i_tx.send(d, nine, par, bp, bs);
    repeat (8) @(posedge clk);
  endtask : tx

  task automatic fill(input int n, input logic [8:0] base);
    for (int i = 0; i < n; i++) begin
      tx(base + 9'(i), 1'b0, 2'b00, 1'b0, 1'b0);
    end
  endtask : fill

  function automatic int thr(input int l);
    return l == 0 ? 1 : (l == 1 ? `URS_DEPTH / 2 : `URS_DEPTH * 3 / 4);
  endfunction : thr

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    repeat (260) @(posedge clk);
    rdchk("status", `URS_OFS_STATUS, 32'hFFFFFFFF, 32'h10);
    rdchk("mask", `URS_OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
    rdchk("config", `URS_OFS_CONFIG, 32'hFFFF0007, {`URS_RST_DIV, 16'h0});
    apb(1'b0, 12'h014, 32'h0);
    check("slverr", 32'(err), 32'h1);
    check("err_data", rd, 32'h0);
    wr(`URS_OFS_CONFIG, 32'h0001_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_level;
    for (int k = 1; k <= 6; k++) begin
      tx(9'(k), 1'b0, 2'b00, 1'b0, 1'b0);
      for (int l = 0; l < 3; l++) begin
        wr(`URS_OFS_STATUS, 32'(l) << 6);
        repeat (3) @(posedge clk);
        check("flag", 32'(rx_flag), 32'(k >= thr(l)));
      end
    end
    wr(`URS_OFS_STATUS, 32'h0);
    for (int k = 1; k <= 6; k++) begin
      rdchk("rxdata", `URS_OFS_RXDATA, 32'h7FF, 32'(k));
    end
    rdchk("empty", `URS_OFS_STATUS, 32'h1, 32'h0);
    check("flag_low", 32'(rx_flag), 32'h0);
    $display("test level done");
  endtask : t_level

  task automatic t_errors;
    wr(`URS_OFS_CONFIG, 32'h0001_0002);
    wr(`URS_OFS_IRQ_MASK, 32'h8);
    fork
      i_tx.send(9'h0A5, 1'b0, 2'b01, 1'b1, 1'b0);
      begin
        repeat (60) @(posedge clk);
        rdchk("busy", `URS_OFS_STATUS, 32'h10, 32'h0);
      end
    join
    repeat (8) @(posedge clk);
    rdchk("parity_error_flag", `URS_OFS_STATUS, 32'h1D, 32'h19);
    check("irq_on", 32'(irq), 32'h1);
    rdchk("istat", `URS_OFS_IRQ_STAT, 32'h8, 32'h8);
    wr(`URS_OFS_IRQ_MASK, 32'h0);
    repeat (3) @(posedge clk);
    check("irq_masked", 32'(irq), 32'h0);
    wr(`URS_OFS_IRQ_STAT, 32'h8);
    rdchk("istat_clr", `URS_OFS_IRQ_STAT, 32'h8, 32'h0);
    wr(`URS_OFS_IRQ_MASK, 32'h8);
    repeat (3) @(posedge clk);
    check("irq_off", 32'(irq), 32'h0);
    rdchk("parity_error_flag_char", `URS_OFS_RXDATA, 32'h7FF, 32'h2A5);
    tx(9'h03C, 1'b0, 2'b01, 1'b0, 1'b1);
    rdchk("framing_error_flag", `URS_OFS_STATUS, 32'h1D, 32'h15);
    rdchk("istat_framing_error_flag", `URS_OFS_IRQ_STAT, 32'h4, 32'h4);
    rdchk("framing_error_flag_char", `URS_OFS_RXDATA, 32'h7FF, 32'h43C);
    rdchk("clean", `URS_OFS_STATUS, 32'h0D, 32'h0);
    wr(`URS_OFS_CONFIG, 32'h0001_0004);
    tx(9'h0A5, 1'b0, 2'b10, 1'b1, 1'b0);
    rdchk("odd_par", `URS_OFS_RXDATA, 32'h7FF, 32'h2A5);
    $display("test errors done");
  endtask : t_errors

  task automatic t_overrun;
    wr(`URS_OFS_CONFIG, 32'h0001_0000);
    fill(9, 9'h010);
    rdchk("ovr_set", `URS_OFS_STATUS, 32'h3, 32'h3);
    rdchk("istat_ovr", `URS_OFS_IRQ_STAT, 32'h2, 32'h2);
    wr(`URS_OFS_STATUS, 32'h2);
    rdchk("ovr_w1", `URS_OFS_STATUS, 32'h2, 32'h2);
    wr(`URS_OFS_STATUS, 32'h0);
    rdchk("flush", `URS_OFS_STATUS, 32'h3, 32'h0);
    check("flush_flag", 32'(rx_flag), 32'h0);
    fill(9, 9'h020);
    rdchk("pop0", `URS_OFS_RXDATA, 32'h1FF, 32'h020);
    tx(9'h099, 1'b0, 2'b00, 1'b0, 1'b0);
    for (int i = 1; i < 8; i++) begin
      rdchk("kept", `URS_OFS_RXDATA, 32'h1FF, 32'h20 + i);
    end
    rdchk("dropped", `URS_OFS_STATUS, 32'h3, 32'h2);
    wr(`URS_OFS_STATUS, 32'h0);
    tx(9'h077, 1'b0, 2'b00, 1'b0, 1'b0);
    rdchk("after_clr", `URS_OFS_RXDATA, 32'h1FF, 32'h077);
    $display("test overrun done");
  endtask : t_overrun

  task automatic t_addr;
    logic [8:0] dat [4];
    logic [3:0] nine, aden, kept;
    dat  = '{9'h055, 9'h1AA, 9'h055, 9'h055};
    nine = 4'b1011;
    aden = 4'b0111;
    kept = 4'b1110;
    for (int i = 0; i < 4; i++) begin
      wr(`URS_OFS_CONFIG, {16'h0001, 15'h0, nine[i]});
      wr(`URS_OFS_STATUS, 32'(aden[i]) << 5);
      tx(dat[i], nine[i], 2'b00, 1'b0, 1'b0);
      rdchk("addr_avail", `URS_OFS_STATUS, 32'h1, 32'(kept[i]));
      if (kept[i]) begin
        rdchk("addr_data", `URS_OFS_RXDATA, 32'h1FF, 32'(dat[i]));
      end
    end
    $display("test address done");
  endtask : t_addr

  initial begin
    rst_b = 1'b0;
    req = '0;
    fail_count = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_level;
    t_errors;
    t_overrun;
    t_addr;
    end_sim;
  end

  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_sim;
  end
endmodule : test_uart_receive_status_irq

bind urs_uart_rx urs_rx_sva i_sva (
  .CLK         (CLK),
  .RST_B       (RST_B),
  .APB_REQ     (APB_REQ),
  .PRDATA      (PRDATA),
  .PREADY      (PREADY),
  .PSLVERR     (PSLVERR),
  .RX          (RX),
  .RX_IRQ_FLAG (RX_IRQ_FLAG),
  .IRQ         (IRQ)
);
`default_nettype wire
